// ---- mux_pkg.sv ----
package mux_pkg;
  // Address frame layout
  localparam int ADDR_FIXED_WIDTH = 4;
  localparam logic [3:0] ADDR_FIXED = 4'h7;   // Fixed upper address bits, arbitrary choice
  localparam int BYTE_BITS = 8;
  localparam int RW_BIT = 0;
  // Control byte fields
  localparam int SEL_WIDTH = 4;
  localparam int CHANNEL_ENABLE_BIT = 3;
  localparam int CHANNEL_COUNT = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Reset input filtering
  localparam int RESET_LOW_MIN_WIDTH_NS = 100;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_LOW_CYCLES =
    (RESET_LOW_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Protocol phases
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WRITE = 3'b011,
    ST_WRITE_ACK = 3'b100,
    ST_READ = 3'b101,
    ST_READ_ACK = 3'b110
  } phase_e;

  // Sampled bus lines after synchronisation
  typedef struct packed {
    logic clk;
    logic data;
  } bus_lines_s;

  // Line events found from one sample to the next
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } bus_events_s;
endpackage

// ---- line_sync.sv ----
module line_sync
  import mux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkPin,
  input wire logic dataPin,
  output mux_pkg::bus_lines_s lines,
  output mux_pkg::bus_events_s events
);
  logic [1:0] clkMeta;
  logic [1:0] dataMeta;
  bus_lines_s prev;

  // Two flip-flops per line; idle bus rests high so reset to one
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clkMeta <= 2'h3;
      dataMeta <= 2'h3;
      prev <= 2'h3;
    end
    else
    begin
      clkMeta <= {clkMeta[0], clkPin};
      dataMeta <= {dataMeta[0], dataPin};
      prev <= {clkMeta[1], dataMeta[1]};
    end
  end

  assign lines = {clkMeta[1], dataMeta[1]};

  // Start and stop: data moves while clock stays high
  always_comb
  begin
    events.start = prev.clk && lines.clk && prev.data && !lines.data;
    events.stop = prev.clk && lines.clk && !prev.data && lines.data;
    events.rise = !prev.clk && lines.clk;
    events.fall = prev.clk && !lines.clk;
  end
endmodule

// ---- mux_i2c_target_reset.sv ----
module mux_i2c_target_reset
  import mux_pkg::*;
#(
  parameter int RESET_CYCLES = RESET_LOW_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic resetPin_n,
  input wire logic [2:0] addressPins,
  input wire logic busClockIn,
  input wire logic busDataIn,
  output logic busDataOut,
  output logic busDataOe,
  output logic [mux_pkg::CHANNEL_COUNT-1:0] channelConnect,
  output logic [7:0] controlStatus
);
  import mux_pkg::*;

  bus_lines_s lines;
  bus_events_s events;
  logic [1:0] resetMeta;
  logic [7:0] resetCount;
  logic busReset;
  logic [2:0] addrLatch;
  logic addrCaught;
  phase_e phase;
  logic [7:0] shiftReg;
  logic [3:0] bitCount;
  logic [7:0] ctrl;
  logic pendingApply;
  logic masterAcked;

  // Lines are asynchronous to clk_sys: synchronised before any use
  line_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clkPin(busClockIn),
    .dataPin(busDataIn),
    .lines(lines),
    .events(events)
  );

  // Reset pin synchroniser and pulse-width counter, so glitches are ignored
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resetMeta <= 2'h3;
      resetCount <= 8'h00;
      busReset <= 1'b0;
    end
    else
    begin
      resetMeta <= {resetMeta[0], resetPin_n};
      if (resetMeta[1])
      begin
        resetCount <= 8'h00;
        busReset <= 1'b0;
      end
      else if (resetCount >= 8'(RESET_CYCLES - 1))
        busReset <= 1'b1;
      else
        resetCount <= resetCount + 8'h01;
    end
  end

  // Address straps caught once after reset release, not under async reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addrLatch <= 3'h0;
      addrCaught <= 1'b0;
    end
    else if (!addrCaught)
    begin
      addrLatch <= addressPins;
      addrCaught <= 1'b1;
    end
  end

  // Protocol state machine: bits sampled on clock rise, driven after fall
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= ST_IDLE;
      shiftReg <= 8'h00;
      bitCount <= 4'h0;
      masterAcked <= 1'b0;
    end
    else if (busReset)
    begin
      phase <= ST_IDLE;
      bitCount <= 4'h0;
      masterAcked <= 1'b0;
    end
    else if (events.start)
    begin
      phase <= ST_ADDR;
      bitCount <= 4'h0;
    end
    else if (events.stop)
      phase <= ST_IDLE;
    else
    begin
      unique case (phase)
        ST_IDLE:
          bitCount <= 4'h0;
        ST_ADDR, ST_WRITE:
          if (events.rise)
          begin
            shiftReg <= {shiftReg[6:0], lines.data};
            bitCount <= bitCount + 4'h1;
          end
          else if (events.fall && bitCount == 4'(BYTE_BITS))
          begin
            bitCount <= 4'h0;
            if (phase == ST_WRITE)
              phase <= ST_WRITE_ACK;
            else if (shiftReg[7:1] == {ADDR_FIXED, addrLatch})
              phase <= ST_ADDR_ACK;
            else
              phase <= ST_IDLE;
          end
        ST_ADDR_ACK, ST_WRITE_ACK:
          if (events.fall)
          begin
            if (phase == ST_ADDR_ACK && shiftReg[RW_BIT])
            begin
              phase <= ST_READ;
              shiftReg <= ctrl;
            end
            else
              phase <= ST_WRITE;
          end
        ST_READ:
          if (events.fall)
          begin
            bitCount <= bitCount + 4'h1;
            if (bitCount == 4'(BYTE_BITS - 1))
              phase <= ST_READ_ACK;
            else
              shiftReg <= {shiftReg[6:0], 1'b0};
          end
        ST_READ_ACK:
          if (events.rise)
            masterAcked <= !lines.data;
          else if (events.fall)
          begin
            bitCount <= 4'h0;
            if (masterAcked)
            begin
              phase <= ST_READ;
              shiftReg <= ctrl;
            end
            else
              phase <= ST_IDLE;
          end
        default:
          phase <= ST_IDLE;
      endcase
    end
  end

  // Control register: each written byte replaces the last, applied on stop
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= CTRL_RESET;
      pendingApply <= 1'b0;
    end
    else if (busReset)
    begin
      ctrl <= CTRL_RESET;
      pendingApply <= 1'b0;
    end
    else if (phase == ST_WRITE && events.fall && bitCount == 4'(BYTE_BITS)
             && !events.start && !events.stop)
    begin
      ctrl <= shiftReg;
      pendingApply <= 1'b1;
    end
    else if (events.stop)
      pendingApply <= 1'b0;
  end

  // Channel outputs change only at stop or on busReset, so lines are high on connect
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channelConnect <= '0;
      controlStatus <= CTRL_RESET;
    end
    else if (busReset)
    begin
      channelConnect <= '0;
      controlStatus <= CTRL_RESET;
    end
    else if (events.stop && pendingApply)
    begin
      controlStatus <= ctrl;
      if (ctrl[CHANNEL_ENABLE_BIT])
        channelConnect <= CHANNEL_COUNT'(1) << ctrl[2:0];
      else
        channelConnect <= '0;
    end
  end

  // Data pin drive: open-drain, only ever pulls low
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      busDataOe <= 1'b0;
    else if (busReset || events.start || events.stop)
      busDataOe <= 1'b0;
    else if (events.fall)
    begin
      // ack pulled low across high phase
      if (phase == ST_WRITE && bitCount == 4'(BYTE_BITS))
        busDataOe <= 1'b1;
      else if (phase == ST_ADDR && bitCount == 4'(BYTE_BITS))
        busDataOe <= (shiftReg[7:1] == {ADDR_FIXED, addrLatch});
      else if ((phase == ST_ADDR_ACK && shiftReg[RW_BIT]) ||
               (phase == ST_READ_ACK && masterAcked))
        busDataOe <= !ctrl[7];
      else if (phase == ST_READ && bitCount != 4'(BYTE_BITS - 1))
        busDataOe <= !shiftReg[6];
      else
        busDataOe <= 1'b0;
    end
  end

  // Output value is always low; the enable alone shapes the wire
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      busDataOut <= 1'b0;
    else
      busDataOut <= 1'b0;
  end
endmodule

// ---- mux_i2c_target_reset_asserts.sv ----
module mux_i2c_target_reset_asserts
  import mux_pkg::*;
#(
  parameter int RESET_CYCLES = RESET_LOW_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic resetPin_n,
  input wire logic [2:0] addressPins,
  input wire logic busClockIn,
  input wire logic busDataIn,
  input wire logic busDataOut,
  input wire logic busDataOe,
  input wire logic [mux_pkg::CHANNEL_COUNT-1:0] channelConnect,
  input wire logic [7:0] controlStatus
);
  import mux_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Outputs are watched even while reset is held
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n |-> channelConnect == 8'h00 && controlStatus == 8'h00 && !busDataOe)
    else $error("outputs not clear in reset");
  pin_reset_a: assert property (
    !resetPin_n [*8] |=> channelConnect == 8'h00 && controlStatus == 8'h00)
    else $error("reset pin did not clear");
  one_channel_a: assert property ($onehot0(channelConnect))
    else $error("several channels connected");
  channel_map_a: assert property (
    channelConnect == (controlStatus[3] ? 8'h01 << controlStatus[2:0] : 8'h00))
    else $error("channel does not match control byte");
  // A stop leaves both lines high, so an applied change must see them high
  apply_on_stop_a: assert property (
    $changed(controlStatus) |-> busClockIn && busDataIn)
    else $error("selection changed outside stop");
  data_low_a: assert property (busDataOut == 1'b0)
    else $error("data line driven high");
  oe_clock_low_a: assert property ($changed(busDataOe) |-> !busClockIn)
    else $error("data moved while clock high");
  ack_hold_a: assert property (
    $rose(busClockIn) && busDataOe |-> busDataOe [*3])
    else $error("pull-down dropped in clock high");
  // Main scenarios
  cover property ($rose(busDataOe));
  cover property ($changed(channelConnect));
  cover property ($fell(resetPin_n));
endmodule

bind mux_i2c_target_reset mux_i2c_target_reset_asserts #(.RESET_CYCLES(RESET_CYCLES)) chk (.*);

// ---- bus_master_model.sv ----
module bus_master_model
(
  output logic sclLow,
  output logic sdaLow,
  input wire logic sdaIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines released; the pull-ups hold them high while idle
  initial
  begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  task automatic start();
    sdaLow = 1'b1;
    #80 sclLow = 1'b1;
  endtask
  // One bit per pulse, data moved in the low phase
  task automatic bitx(input logic b, output logic r);
    #40 sdaLow = !b;
    #40 sclLow = 1'b0;
    #40 r = sdaIn;
    #40 sclLow = 1'b1;
  endtask
  // MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ackOut,
                      output logic [7:0] rx, output logic ackIn);
    for (int i = 7; i >= 0; i--)
      bitx(tx[i], rx[i]);
    bitx(!ackOut, ackIn);
    ackIn = !ackIn;
  endtask
  // Stop, then bus left idle; the clock stands still
  task automatic stop();
    #40 sdaLow = 1'b1;
    #40 sclLow = 1'b0;
    #80 sdaLow = 1'b0;
    #160;
  endtask
endmodule

// ---- mux_i2c_target_reset_tb.sv ----
module mux_i2c_target_reset_tb;
  import mux_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b1;
  logic resetPin_n = 1'b1;
  logic [2:0] addressPins = 3'h5;
  logic sclLow, sdaLow, busDataOut, busDataOe, ack;
  logic [7:0] channelConnect, controlStatus, rx;
  int miscompares = 0;
  int samples_checked = 0;
  localparam logic [7:0] ADDR_W = {ADDR_FIXED, 3'h5, 1'b0};
  always #10 clk_sys = ~clk_sys;
  mux_i2c_target_reset uut (.clk_sys(clk_sys), .rst_n(rst_n), .resetPin_n(resetPin_n),
    .addressPins(addressPins), .busClockIn(!sclLow), .busDataIn(!(sdaLow || busDataOe)),
    .busDataOut(busDataOut), .busDataOe(busDataOe), .channelConnect(channelConnect),
    .controlStatus(controlStatus));
  bus_master_model master (.sclLow(sclLow), .sdaLow(sdaLow), .sdaIn(!(sdaLow || busDataOe)));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One byte written, acknowledge compared with what is expected
  task automatic send(input logic [7:0] b, input logic ackExp);
    master.xfer(b, 1'b0, rx, ack);
    check({7'h0, ack}, {7'h0, ackExp});
  endtask
  task automatic scenWrite();
    master.start();
    send(ADDR_W, 1'b1);
    send(8'hFC, 1'b1);
    check(controlStatus, 8'h00);
    check(channelConnect, 8'h00);
    master.stop();
    check(controlStatus, 8'hFC);
    check(channelConnect, 8'h10);
  endtask
  task automatic scenMulti();
    master.start();
    send(ADDR_W, 1'b1);
    send(8'h09, 1'b1);
    send(8'h0F, 1'b1);
    send(8'h03, 1'b1);
    master.stop();
    check(controlStatus, 8'h03);
    check(channelConnect, 8'h00);
  endtask
  task automatic scenRead();
    master.start();
    send(ADDR_W | 8'h01, 1'b1);
    master.xfer(8'hFF, 1'b1, rx, ack);
    check(rx, 8'h03);
    master.xfer(8'hFF, 1'b0, rx, ack);
    check(rx, 8'h03);
    #100 check({7'h0, busDataOe}, 8'h00);
    check({7'h0, busDataOut}, 8'h00);
    master.stop();
  endtask
  task automatic scenForeign();
    master.start();
    send({ADDR_FIXED, 3'h2, 1'b0}, 1'b0);
    send(8'h08, 1'b0);
    master.stop();
    check(controlStatus, 8'h03);
  endtask
  // Reset pin held well past its minimum width while the bus is idle
  task automatic scenPin();
    master.start();
    send(ADDR_W, 1'b1);
    send(8'h0A, 1'b1);
    master.stop();
    check(channelConnect, 8'h04);
    resetPin_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    #2;
    check(channelConnect, 8'h00);
    check(controlStatus, 8'h00);
    resetPin_n = 1'b1;
  endtask
  // Straps are caught only after reset, so a new address needs a mid-run reset
  task automatic scenStrap();
    addressPins = 3'h2;
    rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #2;
    check(controlStatus, 8'h00);
    master.start();
    send(ADDR_W, 1'b0);
    master.stop();
    master.start();
    send({ADDR_FIXED, 3'h2, 1'b0}, 1'b1);
    send(8'h0D, 1'b1);
    master.stop();
    check(controlStatus, 8'h0D);
    check(channelConnect, 8'h20);
  endtask
  // A hang counts as a mismatch
  initial
  begin
    #400000 miscompares++;
    end_of_test();
  end
  // Reset edge made off time zero so the design clears before the first clock
  initial
  begin
    #2 rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    // Bus moves 2 ns after an edge, never racing the sampling flops
    #2;
    check(channelConnect, 8'h00);
    check(controlStatus, 8'h00);
    scenWrite();
    scenMulti();
    scenRead();
    scenForeign();
    scenPin();
    scenStrap();
    end_of_test();
  end
endmodule
